// ==== verilog/fspc_defs.vh ====
// Constants for the flash self-programming section control block
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// Flash geometry (word addresses)
`define FSPC_ADDR_W 16
`define FSPC_PAGE_W 7
// Fixed boundary: word addresses at or above this lie in the stall section
`define FSPC_STALL_BASE 16'hf000
// Boot size fuse field width and codes (0 = largest boot section)
`define FSPC_BSZ_W 2
`define FSPC_BSZ_4K 2'h0
`define FSPC_BSZ_2K 2'h1
`define FSPC_BSZ_1K 2'h2
`define FSPC_BSZ_512 2'h3
// Boot section start address per fuse code
`define FSPC_BOOT_4K 16'hf000
`define FSPC_BOOT_2K 16'hf800
`define FSPC_BOOT_1K 16'hfc00
`define FSPC_BOOT_512 16'hfe00
// Lock pair patterns (1 = unprogrammed)
`define FSPC_LOCK_NONE 2'h3
`define FSPC_LOCK_NOWR 2'h2
`define FSPC_LOCK_NORD 2'h1
`define FSPC_LOCK_BOTH 2'h0
// Operation codes
`define FSPC_OP_ERASE 2'h1
`define FSPC_OP_WRITE 2'h2
// Default erase/write duration in ns
`define FSPC_PROG_TIME_NS 4500000
`define FSPC_CLK_NS 25
// Controller states
`define FSPC_ST_IDLE 2'h0
`define FSPC_ST_BUSY 2'h1
`define FSPC_ST_DONE 2'h2

`endif

// ==== verilog/fspc_region_decode.v ====
// Region decoder: sorts a flash word address into sections
`timescale 1ns/10ps
`default_nettype none
`include "fspc_defs.vh"

module fspc_region_decode #(
  parameter ADDR_W = `FSPC_ADDR_W
) (
  // Address and fuses
  input wire [ADDR_W-1:0] addr,
  input wire [`FSPC_BSZ_W-1:0] bootSizeFuses,
  // Classification
  output reg inBootSection,
  output wire inStallSection
);

  reg [ADDR_W-1:0] bootBase;

  // Boot start comes from fuses only, every code lies at or above the stall base
  always @* begin
    case (bootSizeFuses)
      `FSPC_BSZ_4K: bootBase = `FSPC_BOOT_4K;
      `FSPC_BSZ_2K: bootBase = `FSPC_BOOT_2K;
      `FSPC_BSZ_1K: bootBase = `FSPC_BOOT_1K;
      default: bootBase = `FSPC_BOOT_512;
    endcase
    inBootSection = (addr >= bootBase);
  end

  // Fixed split, independent of the fuses
  assign inStallSection = (addr >= `FSPC_STALL_BASE);

endmodule // fspc_region_decode
`default_nettype wire

// ==== verilog/fspc_section_ctrl.v ====
// Flash self-programming section control: start gate, stall and busy flag
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "fspc_defs.vh"

module fspc_section_ctrl #(
  parameter ADDR_W = `FSPC_ADDR_W,
  parameter PROG_CYCLES = `FSPC_PROG_TIME_NS / `FSPC_CLK_NS
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Fuses and lock bits
  input wire [`FSPC_BSZ_W-1:0] bootSizeFuses,
  input wire [1:0] applicationLockPair,
  input wire [1:0] bootSectionLockPair,
  // Store request from the CPU
  input wire storeReq,
  input wire [1:0] storeOp,
  input wire [ADDR_W-1:0] storePc,
  input wire [ADDR_W-1:0] storeAddr,
  input wire busyClear,
  // CPU fetch path
  input wire [ADDR_W-1:0] fetchAddr,
  input wire [15:0] flashData,
  output reg [15:0] fetchData_ff,
  output reg fetchValid_ff,
  // Status and control to flash array
  output wire cpuStall,
  output reg concurrentSectionBusy_ff,
  output reg progActive_ff,
  output reg [1:0] progOp_ff,
  output reg [ADDR_W-1:0] progAddr_ff,
  output reg storeRejected_ff
);

  // --------------------------------------------------------------------
  // Section decode
  // --------------------------------------------------------------------
  wire pcInBoot;
  wire tgtInBoot;
  wire tgtInStall;
  wire fetchInStall;
  // Sequencer state is read by the start gate, so it is declared first
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] cnt_ff;
  reg [31:0] nxt_cnt;
  reg tgtStall_ff;

  fspc_region_decode #(.ADDR_W(ADDR_W)) pcDec (
    .addr(storePc),
    .bootSizeFuses(bootSizeFuses),
    .inBootSection(pcInBoot),
    .inStallSection()
  );

  fspc_region_decode #(.ADDR_W(ADDR_W)) tgtDec (
    .addr(storeAddr),
    .bootSizeFuses(bootSizeFuses),
    .inBootSection(tgtInBoot),
    .inStallSection(tgtInStall)
  );

  fspc_region_decode #(.ADDR_W(ADDR_W)) fetchDec (
    .addr(fetchAddr),
    .bootSizeFuses(bootSizeFuses),
    .inBootSection(),
    .inStallSection(fetchInStall)
  );

  // --------------------------------------------------------------------
  // Start gate
  // --------------------------------------------------------------------
  // Write protection per pair; read-only restrictions do not block stores
  wire appWrLocked = (applicationLockPair == `FSPC_LOCK_NOWR) ||
                     (applicationLockPair == `FSPC_LOCK_BOTH);
  wire bootWrLocked = (bootSectionLockPair == `FSPC_LOCK_NOWR) ||
                      (bootSectionLockPair == `FSPC_LOCK_BOTH);
  wire targetLocked = tgtInBoot ? bootWrLocked : appWrLocked;
  wire validOp = (storeOp == `FSPC_OP_ERASE) || (storeOp == `FSPC_OP_WRITE);
  // Requests during an operation are dropped; the array is single-ported
  wire startOk = storeReq && validOp && pcInBoot && !targetLocked &&
                 (state_ff == `FSPC_ST_IDLE);

  // --------------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------------

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      `FSPC_ST_IDLE: begin
        if (startOk) begin
          nxt_state = `FSPC_ST_BUSY;
          nxt_cnt = PROG_CYCLES - 1;
        end
      end
      `FSPC_ST_BUSY: begin
        if (cnt_ff == 32'h0) begin
          nxt_state = `FSPC_ST_DONE;
        end else begin
          nxt_cnt = cnt_ff - 32'h1;
        end
      end
      `FSPC_ST_DONE: nxt_state = `FSPC_ST_IDLE;
      default: nxt_state = `FSPC_ST_IDLE;
    endcase
  end

  // Latch operation and target so software may reuse its pointer
  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= `FSPC_ST_IDLE;
      cnt_ff <= 32'h0;
      progActive_ff <= 1'b0;
      progOp_ff <= 2'h0;
      progAddr_ff <= {ADDR_W{1'b0}};
      tgtStall_ff <= 1'b0;
      storeRejected_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      progActive_ff <= (nxt_state == `FSPC_ST_BUSY);
      storeRejected_ff <= storeReq && !startOk;
      if (startOk) begin
        progOp_ff <= storeOp;
        progAddr_ff <= storeAddr;
        tgtStall_ff <= tgtInStall;
      end
    end
  end

  // --------------------------------------------------------------------
  // Stall and busy flag
  // --------------------------------------------------------------------
  // Stall decided by target section, held for the whole operation
  assign cpuStall = (state_ff == `FSPC_ST_BUSY) && tgtStall_ff;

  // Set wins over a clear in the same cycle; clear ignored unless the sequencer is idle
  always @(posedge sys_clk) begin
    if (rst) begin
      concurrentSectionBusy_ff <= 1'b0;
    end else if (startOk && !tgtInStall) begin
      concurrentSectionBusy_ff <= 1'b1;
    end else if (busyClear && (state_ff == `FSPC_ST_IDLE)) begin
      concurrentSectionBusy_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Fetch path
  // --------------------------------------------------------------------
  // Non-stall fetches blocked while busy flag up or any operation runs; a stall target halts all
  wire concBlocked = concurrentSectionBusy_ff || (state_ff != `FSPC_ST_IDLE);
  wire fetchOk = !cpuStall && (fetchInStall || !concBlocked);

  always @(posedge sys_clk) begin
    if (rst) begin
      fetchData_ff <= 16'h0;
      fetchValid_ff <= 1'b0;
    end else begin
      fetchValid_ff <= fetchOk;
      fetchData_ff <= fetchOk ? flashData : 16'h0;
    end
  end

endmodule // fspc_section_ctrl
`default_nettype wire

// ==== verif/fspc_properties.sv ====
// Port-level checks for the section control block
`timescale 1ns/10ps
`default_nettype none
// ------------------
// Checker
// ------------------
module fspc_properties (
  // Clock, reset and inputs
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] bootSizeFuses,
  input wire logic [1:0] applicationLockPair,
  input wire logic [1:0] bootSectionLockPair,
  input wire logic storeReq,
  input wire logic [1:0] storeOp,
  input wire logic [15:0] storePc,
  input wire logic [15:0] storeAddr,
  input wire logic [15:0] fetchAddr,
  input wire logic [15:0] flashData,
  // Outputs watched
  input wire logic [15:0] fetchData_ff,
  input wire logic fetchValid_ff,
  input wire logic cpuStall,
  input wire logic concurrentSectionBusy_ff,
  input wire logic progActive_ff,
  input wire logic [15:0] progAddr_ff,
  input wire logic storeRejected_ff
);
  // One domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Idle means neither busy nor in the trailing done cycle
  a_app_store_refused: assert property (storeReq && storePc < 16'hf000 |=> storeRejected_ff)
    else $error("store from application section not refused");
  a_boot_store_start: assert property (storeReq && !progActive_ff && !$past(progActive_ff)
    && storePc >= 16'hfe00 && storeOp == 2'h1 && applicationLockPair == 2'h3
    && bootSectionLockPair == 2'h3 |=> progActive_ff && progAddr_ff == $past(storeAddr))
    else $error("boot store did not start with latched target");
  a_fuse_split: assert property (storeReq && bootSizeFuses == 2'h3 && storePc >= 16'hf000
    && storePc < 16'hfe00 |=> storeRejected_ff) else $error("fuse split ignored");
  a_app_lock: assert property (storeReq && applicationLockPair == 2'h2
    && storeAddr < 16'hf000 |=> storeRejected_ff) else $error("locked page written");
  a_stall_span: assert property ($rose(progActive_ff) && progAddr_ff >= 16'hf000
    |-> cpuStall [*8] ##1 !cpuStall) else $error("stall span wrong");
  a_busy_start: assert property ($rose(progActive_ff) && progAddr_ff < 16'hf000
    |-> concurrentSectionBusy_ff && !cpuStall) else $error("busy not set at start");
  a_blocked_read: assert property (fetchValid_ff && $past(fetchAddr) < 16'hf000
    |-> !$past(concurrentSectionBusy_ff) && !$past(progActive_ff)) else $error("blocked read");
  a_stall_fetch: assert property (progActive_ff && !cpuStall && fetchAddr >= 16'hf000
    |=> fetchValid_ff && fetchData_ff == $past(flashData)) else $error("stall fetch lost");
  // Main scenarios reached
  cover property ($rose(cpuStall));
  cover property ($rose(concurrentSectionBusy_ff));
  cover property (storeRejected_ff && progActive_ff);
endmodule // fspc_properties
`default_nettype wire

// ==== verif/fspc_flash_model.sv ====
// Flash array model answering CPU fetch addresses
`timescale 1ns/10ps
`default_nettype none
module fspc_flash_model (
  // Fetch address in, array word out
  input wire logic [15:0] fetchAddr,
  output logic [15:0] flashData
);
  // Content differs per address so stale data is caught
  assign flashData = fetchAddr ^ 16'ha5c3;
endmodule // fspc_flash_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the section control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ------------------
  // Signals, scoreboard
  // ------------------
  localparam int PC = 8;
  logic sys_clk = 0, rst = 1, storeReq = 0, busyClear = 0, prevAct = 0;
  logic [1:0] bootSizeFuses = 2'h3, applicationLockPair = 2'h3;
  logic [1:0] bootSectionLockPair = 2'h3, storeOp = 2'h1, progOp_ff;
  logic [15:0] storePc = 16'h0, storeAddr = 16'h0, fetchAddr = 16'h0, rnd = 16'd5057;
  logic [15:0] flashData, fetchData_ff, progAddr_ff;
  logic fetchValid_ff, cpuStall, concurrentSectionBusy_ff, progActive_ff, storeRejected_ff;
  logic [18:0] notes[$];
  int fails = 0, samples_checked = 0, cycles = 0;
  fspc_section_ctrl #(.PROG_CYCLES(PC)) u_fspc_section_ctrl (.*);
  fspc_flash_model u_fspc_flash_model (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input string what, input logic [18:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // Random fetches, at least half into the stall region; blocked ones must be refused
  always @(posedge sys_clk) begin
    rnd <= lfsr(rnd);
    fetchAddr <= #2 rnd[0] ? {4'hf, rnd[11:0]} : rnd;
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  // Each start or refusal takes the oldest note
  always @(posedge sys_clk) begin
    prevAct <= progActive_ff;
    if ((progActive_ff && !prevAct) || storeRejected_ff)
      check("store", (progActive_ff && !prevAct) ? {1'b1, progOp_ff, progAddr_ff} : 19'h0,
        notes.pop_front());
  end
  // One store; a started one gets a refused request and a busy clear after it
  task automatic store(input logic [15:0] pc, addr, input logic [1:0] op, fu, al, bl,
    input logic acc);
    storePc = pc; storeAddr = addr; storeOp = op; bootSizeFuses = fu;
    applicationLockPair = al; bootSectionLockPair = bl; storeReq = 1;
    notes.push_back(acc ? {1'b1, op, addr} : 19'h0);
    tick(1);
    storeReq = 0;
    storeAddr = lfsr(addr);
    if (acc) begin
      check("stall", cpuStall, addr >= 16'hf000);
      check("busy", concurrentSectionBusy_ff, addr < 16'hf000);
      storeReq = 1;
      notes.push_back(19'h0);
      tick(1);
      storeReq = 0;
      tick(PC);
      check("done", {progActive_ff, cpuStall}, 19'h0);
      tick(1);
      busyClear = 1;
      tick(1);
      busyClear = 0;
      check("clear", concurrentSectionBusy_ff, 19'h0);
    end else tick(2);
  endtask
  initial begin
    tick(5);
    rst = 0;
    store(16'h1000, 16'h0100, 2'h1, 2'h3, 2'h3, 2'h3, 0);
    store(16'hfe00, 16'h0100, 2'h1, 2'h3, 2'h3, 2'h3, 1);
    store(16'hfe10, 16'hfe40, 2'h2, 2'h3, 2'h3, 2'h3, 1);
    store(16'hf100, 16'h0200, 2'h2, 2'h3, 2'h3, 2'h3, 0);
    store(16'hf100, 16'hf040, 2'h2, 2'h0, 2'h3, 2'h3, 1);
    store(16'hfe00, 16'h0200, 2'h2, 2'h3, 2'h2, 2'h3, 0);
    store(16'hfe00, 16'hfe80, 2'h1, 2'h3, 2'h3, 2'h2, 0);
    store(16'hfe00, 16'hfe80, 2'h1, 2'h3, 2'h2, 2'h3, 1);
    store(16'hfe00, 16'h0300, 2'h3, 2'h3, 2'h3, 2'h3, 0);
    give_verdict();
  end
endmodule // tb_top
bind fspc_section_ctrl fspc_properties u_fspc_properties (.*);
`default_nettype wire
